// *** bench/blr_host.sv ***
// Serial bus host model: start, stop, bytes, register access.
// Assumes the bench resolves the pulled-up data wire.
`timescale 1ns/1ps
`default_nettype none

module blr_host (
    // Clock and resolved data wire
    input  wire logic clk,
    input  wire logic sda,
    // Host pins
    output logic      scl = 1'b1,
    output logic      sda_drv = 1'b1
);
    logic [8:0] got;
    task automatic hw(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Start when b is 1, stop when 0; data moves to ~b while the clock is high
    task automatic cond(input logic b);
        sda_drv = b;
        hw(6);
        scl = 1'b1;
        hw(8);
        sda_drv = ~b;
        hw(8);
        scl = ~b;
        hw(6);
    endtask
    // Eight bits then the ack slot; 1 in a slot releases the wire
    task automatic xb(input logic [8:0] w);
        for (int i = 8; i >= 0; i--) begin
            sda_drv = w[i];
            hw(6);
            scl = 1'b1;
            hw(8);
            got[i] = sda;
            scl = 1'b0;
            hw(6);
        end
    endtask
    task automatic acc(input logic [6:0] ad, input logic rnw,
                       input logic [7:0] off, input logic [15:0] wv,
                       output logic [15:0] rv, output logic ok);
        cond(1'b1);
        xb({ad, 2'b01});
        ok = ~got[0];
        xb({off, 1'b1});
        if (rnw) begin
            cond(1'b1);
            xb({ad, 2'b11});
            xb(9'h1FE);
            rv[15:8] = got[8:1];
            xb(9'h1FF);
            rv[7:0] = got[8:1];
        end else begin
            xb({wv[15:8], 1'b1});
            xb({wv[7:0], 1'b1});
        end
        cond(1'b0);
    endtask
endmodule
`default_nettype wire

// *** bench/tb_blr_top.sv ***
// Bench: register bank reached through the serial host model.
// Assumes the host model times the link; faults and diagnostics here.
`timescale 1ns/1ps
`default_nettype none
module tb_blr_top;
    logic               clk = 0, nrst = 0, sel = 1, scl, sda_drv;
    logic               sda_out, sda_oe_n, alert, ok;
    logic [2:0][7:0]    fault_events = '0;
    logic [15:0]        bright, rv, user_two;
    logic [11:0]        led_cur;
    blr_pkg::blr_cfg_t  cfg;
    blr_pkg::blr_diag_t diag = '{8'h5A, 16'h4321, 16'hBEEF, 12'hABC,
                                 10'h2F1, 2'h2, 4'h9, 4'h6, 4'hC};
    int                 fail_count = 0, cmp_count = 0;
    wire logic          sda = sda_drv & (sda_oe_n | sda_out);
    always #5 clk = ~clk;
    blr_top blr_top_inst (.clk(clk), .nrst(nrst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_sel(sel), .fault_events(fault_events), .diag(diag),
        .cfg(cfg), .brightness_out(bright), .led_current(led_cur),
        .user_two(user_two), .fault_alert(alert));
    blr_host blr_host_inst (.clk(clk), .sda(sda), .scl(scl),
        .sda_drv(sda_drv));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    endtask
    // A write checks only that the address was acknowledged
    task automatic x(input logic rnw, input logic [7:0] o,
                     input logic [15:0] v);
        blr_host_inst.acc(7'h3B, rnw, o, v, rv, ok);
        chk(rnw ? rv : 16'(ok), rnw ? v : 16'h1);
    endtask
    task automatic pulse();
        @(negedge clk) fault_events[2][3] = 1'b1;
        @(negedge clk) fault_events = '0;
        repeat (3) @(negedge clk);
    endtask
    task automatic final_report();
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        chk(16'(led_cur), 16'h0FFF);
        chk(user_two, 16'h8000);
        x(1, 8'h00, 16'h0000);
        x(1, 8'h08, 16'hAAAA);
        chk(bright, 16'h4321);
        blr_host_inst.acc(7'h3A, 1'b0, 8'h00, 16'hFFFF, rv, ok);
        chk(16'(ok), 16'h0);
        x(1, 8'h00, 16'h0000);
        x(0, 8'h00, 16'h1234);
        x(0, 8'h02, 16'hF123);
        chk(16'(led_cur), 16'h0123);
        x(1, 8'h02, 16'hF123);
        x(0, 8'h04, 16'h6AB6);
        chk(bright, 16'h1234);
        chk(16'(cfg), 16'h355B);
        x(0, 8'h16, 16'h0000);
        x(1, 8'h14, 16'h005A);
        x(1, 8'h16, 16'h4321);
        x(1, 8'h18, 16'hBEEF);
        x(1, 8'h1A, 16'h0ABC);
        x(1, 8'h1C, 16'h02F1);
        x(1, 8'h1E, 16'h31A6);
        pulse();
        chk(16'(alert), 16'h1);
        x(0, 8'h12, 16'h0040);
        x(1, 8'h12, 16'h0040);
        x(0, 8'h12, 16'h00C0);
        x(1, 8'h12, 16'h0000);
        chk(16'(alert), 16'h0);
        x(0, 8'h0C, 16'h0040);
        x(1, 8'h0C, 16'hAA2A);
        pulse();
        chk(16'(alert), 16'h0);
        x(0, 8'h0C, 16'h00C0);
        chk(16'(alert), 16'h1);
        x(0, 8'h06, 16'h0000);
        chk(16'(alert), 16'h0);
        chk(user_two, 16'h0000);
        x(1, 8'h20, 16'h0000);
        // Mid-run reset must restore the defaults written over above
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        chk(16'(led_cur), 16'h0FFF);
        chk(user_two, 16'h8000);
        x(1, 8'h00, 16'h0000);
        x(1, 8'h12, 16'h0000);
        final_report();
    end
endmodule
`default_nettype wire

// *** rtl/blr_fault_cell.sv ***
// One fault: sticky status flag and its alert enable.
// Assumes the detector pulse and the write strobes share clk.
`timescale 1ns/1ps
`default_nettype none

module blr_fault_cell (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Fault detector
    input  wire logic       fault_evt,
    // Host writes, pair is {clear or high bit, status or low bit}
    input  wire logic       wr_flags,
    input  wire logic       wr_enable,
    input  wire logic [1:0] pair,
    // State
    output logic            status,
    output logic            enable
);

    blr_pkg::blr_cell_t st_reg;
    blr_pkg::blr_cell_t st_next;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        if (wr_flags && pair == blr_pkg::PAIR_CLEAR) begin
            st_next.status = 1'b0;
        end
        if (wr_enable && pair == blr_pkg::EN_WR_OFF) begin
            st_next.enable = 1'b0;
        end
        if (wr_enable && pair == blr_pkg::EN_WR_ON) begin
            st_next.enable = 1'b1;
        end
        // A new event beats a clear in the same cycle
        if (fault_evt) begin
            st_next.status = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg <= '{status: 1'b0, enable: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    assign status = st_reg.status;
    assign enable = st_reg.enable;

    ////////////////////////////////////////////////////////////////////////
    set_wins_a: assert property (@(posedge clk) disable iff (!nrst)
        fault_evt |=> status)
        else $error("fault event lost");

    pair_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_flags && pair == 2'h3 && !fault_evt |=> !status)
        else $error("paired clear did not clear");

    half_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_flags && pair != 2'h3 && !fault_evt |=> status == $past(status))
        else $error("half clear changed status");

    en_off_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_enable && pair == 2'h1 |=> !enable ##1 enable == $past(enable))
        else $error("enable off code failed");

    en_on_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_enable && pair == 2'h3 |=> enable)
        else $error("enable on code failed");

endmodule

`default_nettype wire

// *** rtl/blr_pkg.sv ***
// Constants and carrier types of the backlight host register bank.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
package blr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets on the serial link
    localparam logic [7:0] OFF_BRIGHT     = 8'h00;
    localparam logic [7:0] OFF_CURR       = 8'h02;
    localparam logic [7:0] OFF_USER1      = 8'h04;
    localparam logic [7:0] OFF_USER2      = 8'h06;
    localparam logic [7:0] OFF_SUP_EN     = 8'h08;
    localparam logic [7:0] OFF_BST_EN     = 8'h0A;
    localparam logic [7:0] OFF_STR_EN     = 8'h0C;
    localparam logic [7:0] OFF_SUP_FLAGS  = 8'h0E;
    localparam logic [7:0] OFF_BST_FLAGS  = 8'h10;
    localparam logic [7:0] OFF_STR_FLAGS  = 8'h12;
    localparam logic [7:0] OFF_FSM_DIAG   = 8'h14;
    localparam logic [7:0] OFF_PIN_DIAG   = 8'h16;
    localparam logic [7:0] OFF_POUT_DIAG  = 8'h18;
    localparam logic [7:0] OFF_SINK_DIAG  = 8'h1A;
    localparam logic [7:0] OFF_BOOST_DIAG = 8'h1C;
    localparam logic [7:0] OFF_RDET_DIAG  = 8'h1E;
    localparam logic [7:0] OFF_STEP       = 8'h02;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] RST_BRIGHT = 16'h0000;
    localparam logic [15:0] RST_CURR   = 16'h0FFF;
    localparam logic [15:0] RST_USER1  = 16'h08A3;
    localparam logic [15:0] RST_USER2  = 16'h8000;

    ////////////////////////////////////////////////////////////////////////
    // Link addresses, alert codes, sizes
    localparam logic [6:0] ADDR_LOW     = 7'h3A;
    localparam logic [6:0] ADDR_HIGH    = 7'h3B;
    localparam logic [1:0] EN_WR_OFF    = 2'h1;
    localparam logic [1:0] EN_WR_ON     = 2'h3;
    localparam logic [1:0] PAIR_CLEAR   = 2'h3;
    localparam logic [1:0] SRC_REGISTER = 2'h2;
    localparam int         FAULTS       = 8;
    localparam int         GROUPS       = 3;
    localparam int         GLOBAL_EN    = 15;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int U1_SCURVE = 1;
    localparam int U1_DITHER = 2;
    localparam int U1_RAMP   = 5;
    localparam int U1_SRC    = 8;
    localparam int U1_RANGE  = 10;
    localparam int U1_RATE   = 12;
    localparam int U1_PSEUDO = 14;
    localparam int CURR_W    = 12;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic       pseudo_random_enable;
        logic [1:0] boost_spread_rate;
        logic [1:0] spread_range;
        logic [1:0] brightness_source_select;
        logic [2:0] linear_ramp_duration;
        logic [2:0] dither_select;
        logic       s_curve_smoothing_enable;
    } blr_cfg_t;

    typedef struct packed {
        logic [7:0]  state_machine_now;
        logic [15:0] input_duty_now;
        logic [15:0] output_duty_now;
        logic [11:0] sink_dac_code_now;
        logic [9:0]  boost_target_code;
        logic [1:0]  detected_dimming_mode;
        logic [3:0]  detected_string_phasing;
        logic [3:0]  detected_boost_frequency;
        logic [3:0]  detected_pwm_frequency;
    } blr_diag_t;

    typedef struct packed {
        logic status;
        logic enable;
    } blr_cell_t;

    typedef enum logic [2:0] {
        PH_IDLE, PH_RX, PH_ACK, PH_TX, PH_MACK
    } blr_phase_t;

    typedef struct packed {
        logic [2:0]  scl_s;
        logic [2:0]  sda_s;
        blr_phase_t  ph;
        logic [3:0]  bitc;
        logic [7:0]  sh;
        logic [1:0]  bidx;
        logic        rd;
        logic        txn;
        logic [7:0]  off;
        logic [7:0]  hi;
        logic        sda_low;
        logic [15:0] txw;
        logic        wr;
        logic [7:0]  woff;
        logic [15:0] wdat;
        logic [15:0] bright;
        logic [15:0] curr;
        logic [15:0] user1;
        logic [15:0] user2;
        logic [15:0] bright_out;
        logic        alert;
    } blr_top_t;

endpackage

// *** rtl/blr_top.sv ***
// Host register bank of an LED backlight driver behind a two-wire
// serial target port with 16-bit register values.
// Assumes fault pulses and diagnostics come from logic on clk.
`timescale 1ns/1ps
`default_nettype none

module blr_top (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // Serial link pins
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe_n,
    // Resistor detected address choice
    input  wire logic                  addr_sel,
    // Fault detectors, one pulse per event
    input  wire logic [2:0][7:0]       fault_events,
    // Live diagnostics
    input  wire blr_pkg::blr_diag_t    diag,
    // Settings toward the driver core
    output blr_pkg::blr_cfg_t          cfg,
    output logic [15:0]                brightness_out,
    output logic [11:0]                led_current,
    output logic [15:0]                user_two,
    output logic                       fault_alert
);

    blr_pkg::blr_top_t st_reg;
    blr_pkg::blr_top_t st_next;

    logic [2:0][7:0] flag_q;
    logic [2:0][7:0] en_q;
    logic [15:0]     rdata;
    logic [6:0]      my_addr;
    logic            scl_hi;
    logic            scl_rise;
    logic            scl_fall;
    logic            sda_now;
    logic            start_c;
    logic            stop_c;
    logic            hit;

    ////////////////////////////////////////////////////////////////////////
    // Places each fault bit at bit 2i+hi of a register word
    function automatic logic [15:0] spread(input logic [7:0] v,
                                           input logic       hi);
        logic [15:0] o;
        o = 16'h0000;
        for (int i = 0; i < blr_pkg::FAULTS; i++) begin
            if (hi) begin
                o[2 * i + 1] = v[i];
            end else begin
                o[2 * i] = v[i];
            end
        end
        return o;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Fault cells, group order supply, boost, string
    genvar g;
    genvar i;
    generate
        for (g = 0; g < blr_pkg::GROUPS; g++) begin : grp
            localparam logic [7:0] FO = blr_pkg::OFF_SUP_FLAGS + 8'(2 * g);
            localparam logic [7:0] EO = blr_pkg::OFF_SUP_EN + 8'(2 * g);
            for (i = 0; i < blr_pkg::FAULTS; i++) begin : flt
                blr_fault_cell u_cell (
                    .clk       (clk),
                    .nrst      (nrst),
                    .fault_evt (fault_events[g][i]),
                    .wr_flags  (st_reg.wr && st_reg.woff == FO),
                    .wr_enable (st_reg.wr && st_reg.woff == EO),
                    .pair      (st_reg.wdat[2 * i +: 2]),
                    .status    (flag_q[g][i]),
                    .enable    (en_q[g][i])
                );
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read data for the current offset; diagnostics are never stored
    always_comb begin
        case (st_reg.off)
            blr_pkg::OFF_BRIGHT:     rdata = st_reg.bright;
            blr_pkg::OFF_CURR:       rdata = st_reg.curr;
            blr_pkg::OFF_USER1:      rdata = st_reg.user1;
            blr_pkg::OFF_USER2:      rdata = st_reg.user2;
            blr_pkg::OFF_SUP_EN:     rdata = spread(en_q[0], 1'b1);
            blr_pkg::OFF_BST_EN:     rdata = spread(en_q[1], 1'b1);
            blr_pkg::OFF_STR_EN:     rdata = spread(en_q[2], 1'b1);
            blr_pkg::OFF_SUP_FLAGS:  rdata = spread(flag_q[0], 1'b0);
            blr_pkg::OFF_BST_FLAGS:  rdata = spread(flag_q[1], 1'b0);
            blr_pkg::OFF_STR_FLAGS:  rdata = spread(flag_q[2], 1'b0);
            blr_pkg::OFF_FSM_DIAG: begin
                rdata = {8'h00, diag.state_machine_now};
            end
            blr_pkg::OFF_PIN_DIAG:   rdata = diag.input_duty_now;
            blr_pkg::OFF_POUT_DIAG:  rdata = diag.output_duty_now;
            blr_pkg::OFF_SINK_DIAG: begin
                rdata = {4'h0, diag.sink_dac_code_now};
            end
            blr_pkg::OFF_BOOST_DIAG: begin
                rdata = {6'h00, diag.boost_target_code};
            end
            blr_pkg::OFF_RDET_DIAG: begin
                rdata = {2'h0, diag.detected_pwm_frequency,
                         diag.detected_boost_frequency,
                         diag.detected_string_phasing,
                         diag.detected_dimming_mode};
            end
            default:                 rdata = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Link conditions, from the second and third synchroniser stages
    assign my_addr  = addr_sel ? blr_pkg::ADDR_HIGH
                               : blr_pkg::ADDR_LOW;
    assign scl_hi   = st_reg.scl_s[1] && st_reg.scl_s[2];
    assign scl_rise = st_reg.scl_s[1] && !st_reg.scl_s[2];
    assign scl_fall = !st_reg.scl_s[1] && st_reg.scl_s[2];
    assign sda_now  = st_reg.sda_s[1];
    assign start_c  = scl_hi && st_reg.sda_s[2] && !st_reg.sda_s[1];
    assign stop_c   = scl_hi && !st_reg.sda_s[2] && st_reg.sda_s[1];
    assign hit      = |(flag_q & en_q);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        st_next.scl_s = {st_reg.scl_s[1:0], scl_in};
        st_next.sda_s = {st_reg.sda_s[1:0], sda_in};
        st_next.wr = 1'b0;

        // Commit of a completed write; accepted in any device state
        if (st_reg.wr) begin
            case (st_reg.woff)
                blr_pkg::OFF_BRIGHT: st_next.bright = st_reg.wdat;
                blr_pkg::OFF_CURR:   st_next.curr = st_reg.wdat;
                blr_pkg::OFF_USER1:  st_next.user1 = st_reg.wdat;
                blr_pkg::OFF_USER2:  st_next.user2 = st_reg.wdat;
                default:             st_next.bright = st_reg.bright;
            endcase
        end

        // Byte engine; a start anywhere restarts the frame
        if (start_c) begin
            st_next.ph = blr_pkg::PH_RX;
            st_next.bitc = 4'h0;
            st_next.bidx = 2'h0;
            st_next.sda_low = 1'b0;
        end else if (stop_c) begin
            st_next.ph = blr_pkg::PH_IDLE;
            st_next.sda_low = 1'b0;
        end else begin
            case (st_reg.ph)
                blr_pkg::PH_RX: begin
                    if (scl_rise) begin
                        st_next.sh = {st_reg.sh[6:0], sda_now};
                        st_next.bitc = st_reg.bitc + 4'h1;
                    end else if (scl_fall && st_reg.bitc == 4'h8) begin
                        st_next.bitc = 4'h0;
                        st_next.ph = blr_pkg::PH_ACK;
                        st_next.sda_low = 1'b1;
                        case (st_reg.bidx)
                            2'h0: begin
                                // Foreign address: stay silent
                                if (st_reg.sh[7:1] != my_addr) begin
                                    st_next.ph = blr_pkg::PH_IDLE;
                                    st_next.sda_low = 1'b0;
                                end
                                st_next.rd = st_reg.sh[0];
                                st_next.txn = 1'b0;
                                st_next.bidx = 2'h1;
                            end
                            2'h1: begin
                                st_next.off = st_reg.sh;
                                st_next.bidx = 2'h2;
                            end
                            2'h2: begin
                                st_next.hi = st_reg.sh;
                                st_next.bidx = 2'h3;
                            end
                            default: begin
                                st_next.wr = 1'b1;
                                st_next.woff = st_reg.off;
                                st_next.wdat = {st_reg.hi, st_reg.sh};
                                st_next.off = st_reg.off + blr_pkg::OFF_STEP;
                                st_next.bidx = 2'h2;
                            end
                        endcase
                    end
                end
                blr_pkg::PH_ACK: begin
                    if (st_reg.rd) begin
                        st_next.txw = rdata;
                    end
                    if (scl_fall) begin
                        st_next.ph = st_reg.rd ? blr_pkg::PH_TX
                                               : blr_pkg::PH_RX;
                        st_next.sda_low = st_reg.rd && !st_reg.txw[15];
                    end
                end
                blr_pkg::PH_TX: begin
                    if (scl_fall) begin
                        st_next.txw = {st_reg.txw[14:0], 1'b0};
                        if (st_reg.bitc == 4'h7) begin
                            st_next.bitc = 4'h0;
                            st_next.sda_low = 1'b0;
                            st_next.ph = blr_pkg::PH_MACK;
                            st_next.txn = !st_reg.txn;
                            if (st_reg.txn) begin
                                st_next.off = st_reg.off + blr_pkg::OFF_STEP;
                            end
                        end else begin
                            st_next.bitc = st_reg.bitc + 4'h1;
                            st_next.sda_low = !st_reg.txw[14];
                        end
                    end
                end
                blr_pkg::PH_MACK: begin
                    // After a full word, reload from the next offset
                    if (!st_reg.txn) begin
                        st_next.txw = rdata;
                    end
                    if (scl_rise && sda_now) begin
                        st_next.ph = blr_pkg::PH_IDLE;
                    end else if (scl_fall) begin
                        st_next.ph = blr_pkg::PH_TX;
                        st_next.sda_low = !st_reg.txw[15];
                    end
                end
                default: begin
                    st_next.sda_low = 1'b0;
                end
            endcase
        end

        // Unprogrammed default follows the pin duty measurement
        if (st_reg.user1[blr_pkg::U1_SRC +: 2] == blr_pkg::SRC_REGISTER) begin
            st_next.bright_out = st_reg.bright;
        end else begin
            st_next.bright_out = diag.input_duty_now;
        end
        st_next.alert = st_reg.user2[blr_pkg::GLOBAL_EN]
                        && hit;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg <= '0;
            st_reg.scl_s <= 3'h7;
            st_reg.sda_s <= 3'h7;
            st_reg.ph <= blr_pkg::PH_IDLE;
            st_reg.bright <= blr_pkg::RST_BRIGHT;
            st_reg.curr <= blr_pkg::RST_CURR;
            st_reg.user1 <= blr_pkg::RST_USER1;
            st_reg.user2 <= blr_pkg::RST_USER2;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; the data line is only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe_n = !st_reg.sda_low;
    assign fault_alert = st_reg.alert;
    assign brightness_out = st_reg.bright_out;
    assign led_current = st_reg.curr[blr_pkg::CURR_W-1:0];
    assign user_two = st_reg.user2;
    assign cfg.pseudo_random_enable =
        st_reg.user1[blr_pkg::U1_PSEUDO];
    assign cfg.boost_spread_rate =
        st_reg.user1[blr_pkg::U1_RATE +: 2];
    assign cfg.spread_range = st_reg.user1[blr_pkg::U1_RANGE +: 2];
    assign cfg.brightness_source_select =
        st_reg.user1[blr_pkg::U1_SRC +: 2];
    assign cfg.linear_ramp_duration =
        st_reg.user1[blr_pkg::U1_RAMP +: 3];
    assign cfg.dither_select = st_reg.user1[blr_pkg::U1_DITHER +: 3];
    assign cfg.s_curve_smoothing_enable =
        st_reg.user1[blr_pkg::U1_SCURVE];

    ////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge clk); endclocking
    default disable iff (!nrst);

    bright_reset_a: assert property (
        !$past(nrst) |-> st_reg.bright == 16'h0000 && st_reg.curr == 16'h0FFF)
        else $error("brightness reset value wrong");

    reg_write_a: assert property (
        st_reg.wr && st_reg.woff == 8'h00
        |=> st_reg.bright == $past(st_reg.wdat))
        else $error("brightness write lost");

    ro_ignore_a: assert property (
        st_reg.wr && st_reg.woff >= 8'h14
        |=> $stable(st_reg.user1) && $stable(st_reg.bright))
        else $error("diagnostic write had an effect");

    global_off_a: assert property (
        !st_reg.user2[15] |=> !fault_alert)
        else $error("alert with global enable off");

    alert_cause_a: assert property (
        st_reg.user2[15] && hit |=> fault_alert
        ##1 (fault_alert || !$past(hit) || !$past(st_reg.user2[15])))
        else $error("enabled fault gave no alert");

    src_sel_a: assert property (
        st_reg.user1[9:8] == 2'h2 ##1 st_reg.user1[9:8] == 2'h2
        |-> brightness_out == $past(st_reg.bright))
        else $error("register brightness not selected");

    addr_ack_a: assert property (
        st_reg.ph == blr_pkg::PH_RX && st_reg.bidx == 2'h0 && scl_fall
        && st_reg.bitc == 4'h8 && !start_c && !stop_c
        |=> st_reg.sda_low
            == ($past(st_reg.sh[7:1]) == (addr_sel ? 7'h3B : 7'h3A)))
        else $error("address acknowledge wrong");

endmodule

`default_nettype wire
